//--- pkg/tcc_pkg.sv
// constants shared by the timer channel capture/compare block
// assumes a single 25 MHz peripheral clock and an apb register bus
package tcc_pkg;
  // =====================================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFS_IO_CONTROL = 8'h00;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLES = 8'h08;
  localparam logic [7:0] OFS_GENERAL_REG_A = 8'h0c;
  localparam logic [7:0] OFS_GENERAL_REG_B = 8'h10;
  localparam logic [7:0] OFS_COUNTER = 8'h14;
  // =====================================================================
  // field positions and values
  localparam int IO_A_LSB = 0;
  localparam int IO_B_LSB = 4;
  localparam int FLAG_REG_A = 0;
  localparam int FLAG_REG_B = 1;
  localparam int FLAG_WRAP = 2;
  localparam logic [2:0] IO_CMP_OFF = 3'h0;
  localparam logic [2:0] IO_CMP_LOW = 3'h1;
  localparam logic [2:0] IO_CMP_HIGH = 3'h2;
  localparam logic [2:0] IO_CMP_TOGGLE = 3'h3;
  localparam logic [2:0] IO_CAP_RISE = 3'h4;
  localparam logic [2:0] IO_CAP_FALL = 3'h5;
  localparam logic [2:0] IO_CAP_BOTH = 3'h6;
  // =====================================================================
  // values after reset and fixed read-back bits
  localparam logic [7:0] RST_IO_CONTROL = 8'h08;
  localparam logic [7:0] IO_FIXED_ONES = 8'h08;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h78;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [2:0] RST_IRQ_ENABLES = 3'h0;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_GENERAL_REG = 16'hffff;
  localparam logic [15:0] COUNTER_MAX = 16'hffff;
  localparam logic [15:0] COUNTER_MIN = 16'h0000;
  localparam int SYNC_STAGES = 3;
endpackage

//--- pkg/tcc_flag_if.sv
// carries the event flag requests and bus strobes between the channel
// and its flag keeper; one clock domain only
`timescale 1ns/1ps
interface tcc_flag_if;
  logic [2:0] set;
  logic rd;
  logic wr;
  logic [2:0] wdata;
  logic dma_clr;
  logic [2:0] flags;
  modport keeper (input set, input rd, input wr, input wdata, input dma_clr, output flags);
  modport user (output set, output rd, output wr, output wdata, output dma_clr, input flags);
endinterface

//--- src/tcc_pin_sync.sv
// three-stage synchroniser with edge pulses for one capture pin
// assumes the pin is asynchronous to i_clk_sys
`timescale 1ns/1ps
module tcc_pin_sync (
  input wire logic i_clk_sys, // peripheral clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_pin, // raw pin level
  output logic o_rise, // one-cycle pulse on an accepted rising edge
  output logic o_fall // one-cycle pulse on an accepted falling edge
);
  import tcc_pkg::*;
  logic [SYNC_STAGES-1:0] stage;
  logic level;

  // =====================================================================
  // capture chain; the first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stage <= '0;
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], i_pin};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      level <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end

  assign o_rise = (stage[1] == stage[2]) && stage[2] && !level;
  assign o_fall = (stage[1] == stage[2]) && !stage[2] && level;
endmodule

//--- src/tcc_event_flags.sv
// the three sticky event flags with read-then-write-zero clearing
// assumes rd pulses in a read setup cycle and wr at the apb write access edge
`timescale 1ns/1ps
module tcc_event_flags (
  input wire logic i_clk_sys, // peripheral clock
  input wire logic i_rst, // synchronous reset or standby, active high
  tcc_flag_if.keeper fl // set requests, bus strobes, flag levels
);
  import tcc_pkg::*;
  logic [2:0] armed;
  logic [2:0] clr;
  logic [2:0] next_flags;

  // a flag may clear by a bus write only after it was read as one
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      armed <= '0;
    end else if (fl.rd) begin
      armed <= fl.flags; // RULE15
    end else if (fl.wr) begin
      armed <= '0;
    end
  end

  always_comb begin
    clr = {3{fl.wr}} & armed & ~fl.wdata; // RULE15
    clr[FLAG_REG_A] = clr[FLAG_REG_A] | fl.dma_clr; // RULE18
    next_flags = fl.set | (fl.flags & ~clr); // RULE20
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fl.flags <= RST_FLAGS; // RULE11
    end else begin
      fl.flags <= next_flags;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_set_beats_clear: assert property ( // RULE20
    (fl.set != 3'h0) |=> ((fl.flags & $past(fl.set)) == $past(fl.set)))
    else $error("flag event lost to a clear");
  chk_write_no_set: assert property ( // RULE15
    (fl.set == 3'h0) |=> ((fl.flags & ~$past(fl.flags)) == 3'h0))
    else $error("flag rose without an event");
  chk_clear_after_read: assert property ( // RULE15
    (fl.wr && !fl.dma_clr && fl.set == 3'h0 && armed == 3'h0)
      |=> (fl.flags == $past(fl.flags)))
    else $error("flag cleared without a prior read");
endmodule

//--- src/tcc_channel.sv
// one timer channel: counter, general registers a and b, capture and
// compare control, pin action, event flags and interrupt requests
// assumes an apb master on i_clk_sys and an external count tick source
//
// Summary of operation
// RULE1 - select 000: compare on register a, pin left undriven; reset value
// RULE2 - select 001: compare match on register a drives pin low
// RULE3 - select 010: compare match on register a drives pin high
// RULE4 - select 011: match toggles pin; channel 2 drives high instead
// RULE5 - after reset the compare pin stays low until first match
// RULE6 - select 100: register a captures counter on rising input edge
// RULE7 - select 101: register a captures counter on falling input edge
// RULE8 - select 110: register a captures counter on both input edges
// RULE9 - io control bit 3 always reads one; software writes one
// RULE10 - each set flag with its enable raises an interrupt request
// RULE11 - reset and standby clear flags; bits 6 to 3 read one
// RULE12 - flag register bits 6 to 3 read one; bit 7 undefined
// RULE13 - wrap flag sets on counter wrap up past all ones or down past zero
// RULE14 - downward wrap only possible while up/down counting is selected
// RULE15 - flag clears only by read as one then write zero; one never sets
// RULE16 - register b flag sets on b compare match or b capture
// RULE17 - register a flag sets on a compare match or a capture
// RULE18 - channels 0 to 3: dma start from a request clears a flag
// RULE19 - enable bits 2,1,0 gate wrap, b and a requests
// RULE20 - a set event in the clearing cycle leaves the flag set
// RULE21 - select 111 behaves as capture on both edges
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module tcc_channel #(
  parameter int CHANNEL = 0 // channel index 0..4, shapes toggle and dma
) (
  input wire logic i_clk_sys, // peripheral clock, 25 MHz
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_standby, // standby entry, initialises registers
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic i_count_tick, // one-cycle count pulse from the clock select
  input wire logic i_updown_mode, // counter runs up/down (quadrature or complementary)
  input wire logic i_count_down, // direction while up/down, high counts down
  input wire logic i_dma_ack_a, // dma controller started on the register a request
  input wire logic i_pin_a, // channel pin a input level, asynchronous
  input wire logic i_pin_b, // channel pin b input level, asynchronous
  output logic o_pin_a, // channel pin a output level
  output logic o_pin_a_oe_n, // pin a output enable, low while driving
  output logic o_pin_b, // channel pin b output level
  output logic o_pin_b_oe_n, // pin b output enable, low while driving
  output logic o_reg_a_irq, // register a interrupt request
  output logic o_reg_b_irq, // register b interrupt request
  output logic o_wrap_irq // counter wrap interrupt request
);
  import tcc_pkg::*;

  // =====================================================================
  // helpers
  function automatic logic is_capture(input logic [2:0] sel);
    return sel[2]; // RULE21
  endfunction

  function automatic logic capture_hit(input logic [2:0] sel, input logic rise,
                                       input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      IO_CAP_RISE: hit = rise; // RULE6
      IO_CAP_FALL: hit = fall; // RULE7
      IO_CAP_BOTH: hit = rise | fall; // RULE8
      default: hit = sel[2] & (rise | fall); // RULE21
    endcase
    return hit;
  endfunction

  function automatic logic pin_after_match(input logic [2:0] sel, input logic cur);
    logic v;
    v = cur;
    case (sel)
      IO_CMP_LOW: v = 1'b0; // RULE2
      IO_CMP_HIGH: v = 1'b1; // RULE3
      IO_CMP_TOGGLE: v = (CHANNEL == 2) ? 1'b1 : ~cur; // RULE4
      default: v = cur;
    endcase
    return v;
  endfunction

  // =====================================================================
  // state
  logic init;
  logic [2:0] io_sel_a;
  logic [2:0] io_sel_b;
  logic io_bit7;
  logic [2:0] irq_en;
  logic [15:0] channel_counter;
  logic [15:0] general_reg_a;
  logic [15:0] general_reg_b;
  logic counter_moved;
  logic pin_a_level;
  logic pin_b_level;
  logic rise_a;
  logic fall_a;
  logic rise_b;
  logic fall_b;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic count_dn;
  logic wrap_evt;
  logic match_a;
  logic match_b;
  logic cap_a;
  logic cap_b;
  logic [15:0] next_counter;
  logic [31:0] next_rdata;

  tcc_flag_if fl ();

  assign init = i_rst | i_standby; // RULE11

  // =====================================================================
  // apb slave: zero wait states, read data registered in setup
  assign wr_acc = psel & penable & pwrite;
  // reads act in setup: prdata and the flag arming see the same flag levels
  assign rd_acc = psel & ~penable & ~pwrite;
  assign pready = psel & penable;
  always_comb begin
    case (paddr)
      OFS_IO_CONTROL, OFS_EVENT_FLAGS, OFS_IRQ_ENABLES, OFS_GENERAL_REG_A,
      OFS_GENERAL_REG_B, OFS_COUNTER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      OFS_IO_CONTROL: next_rdata[7:0] = {io_bit7, io_sel_b, 1'b0, io_sel_a} | IO_FIXED_ONES; // RULE9
      OFS_EVENT_FLAGS: next_rdata[7:0] = {5'h00, fl.flags} | FLAGS_FIXED_ONES; // RULE12
      OFS_IRQ_ENABLES: next_rdata[7:0] = {5'h00, irq_en} | FLAGS_FIXED_ONES;
      OFS_GENERAL_REG_A: next_rdata[15:0] = general_reg_a;
      OFS_GENERAL_REG_B: next_rdata[15:0] = general_reg_b;
      OFS_COUNTER: next_rdata[15:0] = channel_counter;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      prdata <= next_rdata;
    end
  end

  // =====================================================================
  // control registers; bit 7 of the io control keeps what was written
  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      io_sel_a <= RST_IO_CONTROL[IO_A_LSB +: 3]; // RULE1
      io_sel_b <= RST_IO_CONTROL[IO_B_LSB +: 3];
      io_bit7 <= RST_IO_CONTROL[7];
    end else if (wr_acc && paddr == OFS_IO_CONTROL) begin
      io_sel_a <= pwdata[IO_A_LSB +: 3];
      io_sel_b <= pwdata[IO_B_LSB +: 3];
      io_bit7 <= pwdata[7];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      irq_en <= RST_IRQ_ENABLES;
    end else if (wr_acc && paddr == OFS_IRQ_ENABLES) begin
      irq_en <= pwdata[2:0]; // RULE19
    end
  end

  // =====================================================================
  // counter; downward steps only while up/down counting is selected
  assign count_dn = i_updown_mode & i_count_down; // RULE14
  assign wrap_evt = i_count_tick & (count_dn ? (channel_counter == COUNTER_MIN)
                                             : (channel_counter == COUNTER_MAX)); // RULE13
  assign next_counter = count_dn ? channel_counter - 16'h0001 : channel_counter + 16'h0001;

  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      channel_counter <= RST_COUNTER;
    end else if (i_count_tick) begin
      channel_counter <= next_counter;
    end else if (wr_acc && paddr == OFS_COUNTER) begin
      channel_counter <= pwdata[15:0];
    end
  end

  // compare fires once per counter step, not for every cycle it sits equal
  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      counter_moved <= 1'b0;
    end else begin
      counter_moved <= i_count_tick;
    end
  end

  // =====================================================================
  // capture inputs and compare matches
  tcc_pin_sync u_sync_a (
    .i_clk_sys(i_clk_sys),
    .i_rst(init),
    .i_pin(i_pin_a),
    .o_rise(rise_a),
    .o_fall(fall_a)
  );

  tcc_pin_sync u_sync_b (
    .i_clk_sys(i_clk_sys),
    .i_rst(init),
    .i_pin(i_pin_b),
    .o_rise(rise_b),
    .o_fall(fall_b)
  );

  assign match_a = !is_capture(io_sel_a) && counter_moved && channel_counter == general_reg_a;
  assign match_b = !is_capture(io_sel_b) && counter_moved && channel_counter == general_reg_b;
  assign cap_a = capture_hit(io_sel_a, rise_a, fall_a);
  assign cap_b = capture_hit(io_sel_b, rise_b, fall_b);

  // a capture in the same cycle as a software write wins, it is the event
  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      general_reg_a <= RST_GENERAL_REG;
    end else if (cap_a) begin
      general_reg_a <= channel_counter; // RULE6 RULE7 RULE8
    end else if (wr_acc && paddr == OFS_GENERAL_REG_A) begin
      general_reg_a <= pwdata[15:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      general_reg_b <= RST_GENERAL_REG;
    end else if (cap_b) begin
      general_reg_b <= channel_counter;
    end else if (wr_acc && paddr == OFS_GENERAL_REG_B) begin
      general_reg_b <= pwdata[15:0];
    end
  end

  // =====================================================================
  // pin action; level stays low from reset until the first match
  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      pin_a_level <= 1'b0; // RULE5
    end else if (match_a) begin
      pin_a_level <= pin_after_match(io_sel_a, pin_a_level); // RULE2 RULE3 RULE4
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (init) begin
      pin_b_level <= 1'b0;
    end else if (match_b) begin
      pin_b_level <= pin_after_match(io_sel_b, pin_b_level);
    end
  end

  assign o_pin_a = pin_a_level;
  assign o_pin_a_oe_n = is_capture(io_sel_a) | (io_sel_a == IO_CMP_OFF); // RULE1
  assign o_pin_b = pin_b_level;
  assign o_pin_b_oe_n = is_capture(io_sel_b) | (io_sel_b == IO_CMP_OFF);

  // =====================================================================
  // event flags and requests
  assign fl.set[FLAG_REG_A] = match_a | cap_a; // RULE17
  assign fl.set[FLAG_REG_B] = match_b | cap_b; // RULE16
  assign fl.set[FLAG_WRAP] = wrap_evt; // RULE13
  assign fl.rd = rd_acc && paddr == OFS_EVENT_FLAGS;
  assign fl.wr = wr_acc && paddr == OFS_EVENT_FLAGS;
  assign fl.wdata = pwdata[2:0];
  // channel 4 has no dma path for its register a request
  assign fl.dma_clr = (CHANNEL < 4) ? i_dma_ack_a : 1'b0; // RULE18

  tcc_event_flags u_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst(init),
    .fl(fl.keeper)
  );

  assign o_reg_a_irq = fl.flags[FLAG_REG_A] & irq_en[FLAG_REG_A]; // RULE10 RULE19
  assign o_reg_b_irq = fl.flags[FLAG_REG_B] & irq_en[FLAG_REG_B]; // RULE10 RULE19
  assign o_wrap_irq = fl.flags[FLAG_WRAP] & irq_en[FLAG_WRAP]; // RULE10 RULE19

  // =====================================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (init);

  sequence s_match_a;
    match_a && !i_count_tick;
  endsequence

  chk_pin_low_drive: assert property ( // RULE2
    (s_match_a and io_sel_a == IO_CMP_LOW) |=> (o_pin_a == 1'b0 && !o_pin_a_oe_n))
    else $error("pin a not driven low on match");
  chk_pin_high_drive: assert property ( // RULE3
    (s_match_a and io_sel_a == IO_CMP_HIGH) |=> o_pin_a == 1'b1)
    else $error("pin a not driven high on match");
  chk_pin_toggle: assert property ( // RULE4
    (s_match_a and io_sel_a == IO_CMP_TOGGLE)
      |=> o_pin_a == ((CHANNEL == 2) ? 1'b1 : !$past(o_pin_a)))
    else $error("pin a toggle wrong");
  chk_pin_still: assert property ( // RULE5
    !match_a |=> $stable(o_pin_a))
    else $error("pin a changed without a match");
  chk_capture_load: assert property ( // RULE6
    cap_a |=> (general_reg_a == $past(channel_counter) && fl.flags[FLAG_REG_A]))
    else $error("capture did not load register a");
  chk_wrap_sets: assert property ( // RULE13
    wrap_evt |=> (fl.flags[FLAG_WRAP]
      && channel_counter == ($past(count_dn) ? COUNTER_MAX : COUNTER_MIN)))
    else $error("wrap flag missed");
  chk_no_underflow: assert property ( // RULE14
    !i_updown_mode && i_count_tick && channel_counter == 16'h0000 |=> channel_counter == 16'h0001)
    else $error("down step outside up/down mode");
  chk_irq_gate: assert property ( // RULE10
    o_wrap_irq == (fl.flags[FLAG_WRAP] && irq_en[FLAG_WRAP]))
    else $error("wrap request not gated by its enable");
  chk_reserved_io: assert property ( // RULE9
    (psel && !penable && !pwrite && paddr == OFS_IO_CONTROL) |=> prdata[3] == 1'b1)
    else $error("io control bit 3 read zero");
  chk_reserved_flags: assert property ( // RULE12
    (psel && !penable && !pwrite && paddr == OFS_EVENT_FLAGS) |=> prdata[6:3] == 4'hf)
    else $error("flag bits 6..3 read zero");
  chk_reg_b_flag: assert property ( // RULE16
    (match_b || cap_b) |=> fl.flags[FLAG_REG_B])
    else $error("register b flag missed");
  chk_dma_clear: assert property ( // RULE18
    (fl.dma_clr && !fl.set[FLAG_REG_A]) |=> !fl.flags[FLAG_REG_A])
    else $error("dma start left register a flag set");
  chk_pin_undriven: assert property ( // RULE1
    (io_sel_a == IO_CMP_OFF) |-> o_pin_a_oe_n)
    else $error("pin a driven while compare output is off");
endmodule

//--- test/tcc_dma_model.sv
// far side model: a dma controller that answers the register a request
// assumes the request is a level that falls once the flag is cleared
`timescale 1ns/1ps
module tcc_dma_model #(
  parameter int LAT = 2 // one less than the cycles from request to transfer start
) (
  input wire logic i_clk_sys, // peripheral clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_enable, // model answers only while high
  input wire logic i_req, // register a interrupt request
  output logic o_ack // one-cycle transfer start pulse
);
  // ==================================================================
  // request to start pulse
  logic [3:0] dly;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_enable) begin
      dly <= 4'h0;
      o_ack <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      if (i_req && !o_ack) begin
        dly <= dly + 4'h1;
      end
      // a transfer start is what clears the flag on the device side
      if (i_req && !o_ack && dly == 4'(LAT)) begin
        o_ack <= 1'b1;
        dly <= 4'h0;
      end
    end
  end
endmodule

//--- test/tb_timer_channel_capture_compare_status.sv
// self-checking bench for one timer channel, driven over apb
// assumes the dma model and a channel built with CHANNEL 0
`timescale 1ns/1ps
module tb_timer_channel_capture_compare_status;
  import tcc_pkg::*;
  logic clk, rst, stby, psel, penable, pwrite, tick, upd, down, pin_a, pin_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, last_err, dma_en, dma_ack;
  logic po_a, oe_a_n, po_b, oe_b_n, irq_a, irq_b, irq_w;
  int n_mismatch, checks, n_ack;
  tcc_channel #(.CHANNEL(0)) i_dut (.i_clk_sys(clk), .i_rst(rst), .i_standby(stby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_count_tick(tick),
    .i_updown_mode(upd), .i_count_down(down), .i_dma_ack_a(dma_ack), .i_pin_a(pin_a),
    .i_pin_b(pin_b), .o_pin_a(po_a), .o_pin_a_oe_n(oe_a_n), .o_pin_b(po_b),
    .o_pin_b_oe_n(oe_b_n), .o_reg_a_irq(irq_a), .o_reg_b_irq(irq_b), .o_wrap_irq(irq_w));
  tcc_dma_model i_dma (.i_clk_sys(clk), .i_rst(rst), .i_enable(dma_en), .i_req(irq_a),
    .o_ack(dma_ack));
  always @(posedge clk) if (dma_ack === 1'b1) n_ack++;
  // ==================================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  // ==================================================================
  // bus and compare tasks; every driver task starts on a fresh edge
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    cmp_reg(q, e);
  endtask
  task automatic clr();
    logic [31:0] q;
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0, q);
    wr(OFS_EVENT_FLAGS, 32'h78);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset();
    rd(OFS_IO_CONTROL, 32'h08);
    rd(OFS_EVENT_FLAGS, 32'h78);
    rd(OFS_IRQ_ENABLES, 32'h78);
    rd(OFS_GENERAL_REG_A, 32'hffff);
    rd(OFS_COUNTER, 32'h0);
    cmp_pin(oe_a_n, 1'b1);
    cmp_pin(po_a, 1'b0);
    cmp_pin(oe_b_n, 1'b1);
    cmp_pin(po_b, 1'b0);
    wr(OFS_IO_CONTROL, 32'h00);
    rd(OFS_IO_CONTROL, 32'h08);
  endtask
  task automatic t_compare();
    logic [2:0] m;
    for (int i = 1; i <= 3; i++) begin
      m = 3'(i);
      wr(OFS_IO_CONTROL, {28'h0, 1'b1, m});
      wr(OFS_GENERAL_REG_A, 32'h5);
      wr(OFS_COUNTER, 32'h4);
      wt(1);
      cmp_pin(po_a, i == 3);
      cmp_pin(oe_a_n, 1'b0);
      step();
      wt(3);
      cmp_pin(po_a, i == 2);
    end
    rd(OFS_EVENT_FLAGS, 32'h79);
    cmp_pin(irq_a, 1'b0);
    wr(OFS_IRQ_ENABLES, 32'h79);
    wt(1);
    cmp_pin(irq_a, 1'b1);
    cmp_pin(irq_w, 1'b0);
  endtask
  task automatic t_clear();
    // a write with ones disarms the earlier read without clearing
    wr(OFS_EVENT_FLAGS, 32'h7f);
    wr(OFS_EVENT_FLAGS, 32'h78);
    rd(OFS_EVENT_FLAGS, 32'h79);
    wr(OFS_EVENT_FLAGS, 32'h78);
    rd(OFS_EVENT_FLAGS, 32'h78);
    wr(OFS_EVENT_FLAGS, 32'h7f);
    rd(OFS_EVENT_FLAGS, 32'h78);
    cmp_pin(irq_a, 1'b0);
  endtask
  task automatic t_wrap();
    wr(OFS_IO_CONTROL, 32'h08);
    wr(OFS_IRQ_ENABLES, 32'h7c);
    wr(OFS_COUNTER, 32'hffff);
    step();
    wt(2);
    rd(OFS_COUNTER, 32'h0);
    rd(OFS_EVENT_FLAGS, 32'h7c);
    cmp_pin(irq_w, 1'b1);
    wr(OFS_EVENT_FLAGS, 32'h78);
    rd(OFS_EVENT_FLAGS, 32'h78);
    @(posedge clk);
    upd <= 1'b1;
    down <= 1'b1;
    step();
    wt(2);
    rd(OFS_COUNTER, 32'hffff);
    // register b still holds its reset value, so the down wrap also matches b
    rd(OFS_EVENT_FLAGS, 32'h7e);
    cmp_pin(irq_b, 1'b0);
    wr(OFS_IRQ_ENABLES, 32'h7e);
    wt(1);
    cmp_pin(irq_b, 1'b1);
    @(posedge clk);
    upd <= 1'b0;
    down <= 1'b0;
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    rd(OFS_EVENT_FLAGS, 32'h78);
    rd(OFS_IRQ_ENABLES, 32'h78);
  endtask
  task automatic t_capture();
    logic [2:0] m;
    for (int i = 4; i <= 7; i++) begin
      m = 3'(i);
      wr(OFS_IO_CONTROL, {28'h0, 1'b1, m});
      wr(OFS_GENERAL_REG_A, 32'h0);
      wr(OFS_COUNTER, 32'h100 + i);
      @(posedge clk);
      pin_a <= 1'b1;
      wt(8);
      rd(OFS_GENERAL_REG_A, (i == 5) ? 32'h0 : 32'h100 + i);
      wr(OFS_COUNTER, 32'h200 + i);
      @(posedge clk);
      pin_a <= 1'b0;
      wt(8);
      rd(OFS_GENERAL_REG_A, (i == 4) ? 32'h100 + i : 32'h200 + i);
      cmp_pin(oe_a_n, 1'b1);
    end
    rd(OFS_EVENT_FLAGS, 32'h79);
    wr(OFS_EVENT_FLAGS, 32'h78);
    wr(OFS_IO_CONTROL, 32'h48);
    wr(OFS_COUNTER, 32'h33);
    @(posedge clk);
    pin_b <= 1'b1;
    wt(8);
    rd(OFS_GENERAL_REG_B, 32'h33);
    rd(OFS_EVENT_FLAGS, 32'h7a);
    wr(OFS_EVENT_FLAGS, 32'h78);
  endtask
  task automatic t_dma();
    wr(OFS_IRQ_ENABLES, 32'h79);
    wr(OFS_IO_CONTROL, 32'h0a);
    wr(OFS_GENERAL_REG_A, 32'h5);
    wr(OFS_COUNTER, 32'h4);
    @(posedge clk);
    dma_en <= 1'b1;
    step();
    wt(10);
    cmp_pin(n_ack == 1, 1'b1);
    cmp_pin(irq_a, 1'b0);
    rd(OFS_EVENT_FLAGS, 32'h78);
    @(posedge clk);
    dma_en <= 1'b0;
  endtask
  task automatic t_unmapped();
    logic [31:0] q;
    apb(1'b1, 8'h40, 32'h5a, q);
    cmp_pin(last_err, 1'b1);
    rd(8'h40, 32'h0);
    cmp_pin(last_err, 1'b1);
    rd(OFS_IO_CONTROL, 32'h0a);
  endtask
  // ==================================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    n_ack = 0;
    rst = 1'b1;
    stby = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick = 1'b0;
    upd = 1'b0;
    down = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    dma_en = 1'b0;
    last_err = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_compare();
    t_clear();
    t_wrap();
    t_capture();
    t_dma();
    t_unmapped();
    wt(2);
    print_verdict();
  end
endmodule
